// File: mix_defines.svh
// constants for the instruction execution subset
// Summary of operation
// - nibble exchange memory into accumulator, flags kept
// - skip next when memory byte is zero
// - copy memory to acc, skip if zero
// - skip next when selected bit is zero
// - table read via both pointers to memory, latch
// - table read last page via low pointer
// - increment low pointer, then paged table read
// - increment low pointer, then last page read
// - xor acc with memory or immediate, zero flag
// - long forms address any memory section directly
// - add with carry, five flags updated
// - add without carry, five flags updated
// - and/or acc with memory, zero flag only
// - or into memory, zero flag only
// - clear byte or single bit, no flags
// - complement memory to memory or acc, zero flag
// - decimal adjust acc into memory, carry only
// - decrement memory to memory or acc, zero flag
// - increment memory to memory or acc, zero flag
// - move memory to acc or acc to memory
// - rotate left, bit 7 into bit 0
// - rotate left through carry into memory
`ifndef MIX_DEFINES_SVH
`define MIX_DEFINES_SVH
`define MIX_ACC_RESET 8'h00
`define MIX_TBL_RESET 8'h00
`define MIX_LAST_PAGE 8'hff
`define MIX_BCD_LIMIT 4'h9
`define MIX_BCD_FIX 4'h6
`define MIX_SKIP_CYCLES 2'h2
`endif

// File: mix_pkg.sv
// types for the instruction execution subset
package mix_pkg;
	typedef enum logic [4:0] {
		MIX_NOP, MIX_NIBX, MIX_SKZ, MIX_SKZA, MIX_SKZBIT,
		MIX_TRD, MIX_TRDL, MIX_ITRD, MIX_ITRDL,
		MIX_XOR, MIX_XORMEM, MIX_XORI,
		MIX_ADC, MIX_ADCM, MIX_ADD, MIX_ADDM,
		MIX_AND, MIX_ANDM, MIX_OR, MIX_ORM,
		MIX_CLR, MIX_CLRBIT, MIX_CPL, MIX_CPLA, MIX_DAA,
		MIX_DEC, MIX_DECA, MIX_INC, MIX_INCA,
		MIX_MOVA, MIX_MOVM, MIX_RL
	} mix_op_e;
	typedef enum logic [1:0] {MIX_RLM, MIX_RLA, MIX_RLCM} mix_rot_e;
	typedef enum {MIX_RUN, MIX_TREAD, MIX_DUMMY} mix_state_e;
endpackage : mix_pkg

// File: mix_exec.sv
// execution unit for part of the 8-bit core instruction set
`timescale 1ns/1ps
`include "mix_defines.svh"
module mix_exec import mix_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// decoded instruction
	input wire logic op_valid,
	input wire mix_op_e op,
	input wire mix_rot_e rot_mode,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] imm,
	input wire logic [7:0] mem_addr,
	input wire logic [1:0] mem_section,
	input wire logic long_form,
	input wire logic [1:0] cur_section,
	// data memory operand
	input wire logic [7:0] mem_rdata,
	// program memory read
	input wire logic [15:0] prog_rdata,
	input wire logic prog_rvalid,
	// execution results
	output logic busy,
	output logic mem_we,
	output logic [9:0] mem_waddr,
	output logic [7:0] mem_wdata,
	output logic prog_req,
	output logic [15:0] prog_addr,
	output logic skip_next,
	output logic [7:0] acc,
	output logic [7:0] tbl_low,
	output logic [7:0] tbl_high,
	output logic [7:0] tbl_latch,
	output logic flag_c,
	output logic flag_z,
	output logic arith_range_flag,
	output logic nibble_carry_flag,
	output logic signed_less_flag
);
	// ==========================================================
	// helpers
	function automatic logic [9:0] mix_addr(input logic lf, input logic [1:0] sec,
		input logic [1:0] cur, input logic [7:0] a);
		mix_addr = {(lf ? sec : cur), a};
	endfunction : mix_addr

	function automatic logic [11:0] mix_add(input logic [7:0] a, input logic [7:0] b,
		input logic ci);
		logic [4:0] lo;
		logic [8:0] s;
		logic rng;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		rng = (a[7] == b[7]) && (s[7] != a[7]);
		// {signed less, range, nibble carry, carry, result}
		mix_add = {rng ^ s[7], rng, lo[4], s[8], s[7:0]};
	endfunction : mix_add

	// ==========================================================
	// state
	mix_state_e state, next_state;
	logic next_busy, next_mem_we, next_prog_req, next_skip_next;
	logic [9:0] next_mem_waddr, hold_addr, next_hold_addr;
	logic [7:0] next_mem_wdata, next_acc, next_tbl_low, next_tbl_high, next_tbl_latch;
	logic [15:0] next_prog_addr;
	logic next_c, next_z, next_range, next_nib, next_sless;
	logic [7:0] res;
	logic [11:0] sum;
	logic [7:0] daa;
	logic daa_c;

	// ==========================================================
	// next values
	always_comb begin
		next_state = state;
		next_busy = 1'b0;
		next_mem_we = 1'b0;
		next_mem_waddr = mem_waddr;
		next_mem_wdata = mem_wdata;
		next_prog_req = 1'b0;
		next_prog_addr = prog_addr;
		next_skip_next = 1'b0;
		next_hold_addr = hold_addr;
		next_acc = acc;
		next_tbl_low = tbl_low;
		next_tbl_high = tbl_high;
		next_tbl_latch = tbl_latch;
		next_c = flag_c;
		next_z = flag_z;
		next_range = arith_range_flag;
		next_nib = nibble_carry_flag;
		next_sless = signed_less_flag;
		res = 8'h00;
		sum = 12'h000;
		daa = acc;
		daa_c = flag_c;
		if (acc[3:0] > `MIX_BCD_LIMIT || nibble_carry_flag) begin
			daa = acc + {4'h0, `MIX_BCD_FIX};
		end
		if (daa[7:4] > `MIX_BCD_LIMIT || flag_c || daa < acc) begin
			daa = daa + {`MIX_BCD_FIX, 4'h0};
			daa_c = 1'b1;
		end
		case (state)
		MIX_RUN: begin
			if (op_valid) begin
				next_mem_waddr = mix_addr(long_form, mem_section, cur_section, mem_addr);
				case (op)
				MIX_NIBX: next_acc = {mem_rdata[3:0], mem_rdata[7:4]};
				MIX_SKZ: begin
					if (mem_rdata == 8'h00) begin
						next_skip_next = 1'b1;
						next_busy = 1'b1;
						next_state = MIX_DUMMY;
					end
				end
				MIX_SKZA: begin
					next_acc = mem_rdata;
					if (mem_rdata == 8'h00) begin
						next_skip_next = 1'b1;
						next_busy = 1'b1;
						next_state = MIX_DUMMY;
					end
				end
				MIX_SKZBIT: begin
					if (!mem_rdata[bit_sel]) begin
						next_skip_next = 1'b1;
						next_busy = 1'b1;
						next_state = MIX_DUMMY;
					end
				end
				MIX_TRD, MIX_TRDL, MIX_ITRD, MIX_ITRDL: begin
					// pointer bump lands before the address is formed
					res = (op == MIX_ITRD || op == MIX_ITRDL) ? tbl_low + 8'h01 : tbl_low;
					next_tbl_low = res;
					if (op == MIX_TRD || op == MIX_ITRD) begin
						next_prog_addr = {tbl_high, res};
					end else begin
						next_prog_addr = {`MIX_LAST_PAGE, res};
					end
					next_hold_addr = next_mem_waddr;
					next_prog_req = 1'b1;
					next_busy = 1'b1;
					next_state = MIX_TREAD;
				end
				MIX_XOR, MIX_XORMEM, MIX_XORI, MIX_AND, MIX_ANDM, MIX_OR, MIX_ORM: begin
					case (op)
					MIX_XORI: res = acc ^ imm;
					MIX_XOR, MIX_XORMEM: res = acc ^ mem_rdata;
					MIX_AND, MIX_ANDM: res = acc & mem_rdata;
					default: res = acc | mem_rdata;
					endcase
					next_z = (res == 8'h00);
					if (op == MIX_XORMEM || op == MIX_ANDM || op == MIX_ORM) begin
						next_mem_we = 1'b1;
						next_mem_wdata = res;
					end else begin
						next_acc = res;
					end
				end
				MIX_ADC, MIX_ADCM, MIX_ADD, MIX_ADDM: begin
					sum = mix_add(acc, mem_rdata,
						(op == MIX_ADC || op == MIX_ADCM) && flag_c);
					{next_sless, next_range, next_nib, next_c} = sum[11:8];
					next_z = (sum[7:0] == 8'h00);
					if (op == MIX_ADCM || op == MIX_ADDM) begin
						next_mem_we = 1'b1;
						next_mem_wdata = sum[7:0];
					end else begin
						next_acc = sum[7:0];
					end
				end
				MIX_CLR, MIX_CLRBIT: begin
					next_mem_we = 1'b1;
					next_mem_wdata = 8'h00;
					if (op == MIX_CLRBIT) begin
						next_mem_wdata = mem_rdata & ~(8'h01 << bit_sel);
					end
				end
				MIX_CPL, MIX_DEC, MIX_INC, MIX_CPLA, MIX_DECA, MIX_INCA: begin
					case (op)
					MIX_CPL, MIX_CPLA: res = ~mem_rdata;
					MIX_DEC, MIX_DECA: res = mem_rdata - 8'h01;
					default: res = mem_rdata + 8'h01;
					endcase
					next_z = (res == 8'h00);
					if (op == MIX_CPL || op == MIX_DEC || op == MIX_INC) begin
						next_mem_we = 1'b1;
						next_mem_wdata = res;
					end else begin
						next_acc = res;
					end
				end
				MIX_DAA: begin
					next_mem_we = 1'b1;
					next_mem_wdata = daa;
					next_c = daa_c;
				end
				MIX_MOVA: next_acc = mem_rdata;
				MIX_MOVM: begin
					next_mem_we = 1'b1;
					next_mem_wdata = acc;
				end
				MIX_RL: begin
					case (rot_mode)
					MIX_RLA: next_acc = {mem_rdata[6:0], mem_rdata[7]};
					MIX_RLCM: begin
						next_mem_we = 1'b1;
						next_mem_wdata = {mem_rdata[6:0], flag_c};
						next_c = mem_rdata[7];
					end
					default: begin
						next_mem_we = 1'b1;
						next_mem_wdata = {mem_rdata[6:0], mem_rdata[7]};
					end
					endcase
				end
				default: ;
				endcase
			end
		end
		MIX_TREAD: begin
			next_busy = 1'b1;
			next_prog_req = 1'b1;
			if (prog_rvalid) begin
				next_prog_req = 1'b0;
				next_busy = 1'b0;
				next_mem_we = 1'b1;
				next_mem_waddr = hold_addr;
				next_mem_wdata = prog_rdata[7:0];
				next_tbl_latch = prog_rdata[15:8];
				next_state = MIX_RUN;
			end
		end
		MIX_DUMMY: begin
			// the dummy slot: the fetched instruction is discarded
			next_state = MIX_RUN;
		end
		default: next_state = MIX_RUN;
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= MIX_RUN;
			busy <= 1'b0;
			mem_we <= 1'b0;
			mem_waddr <= 10'h000;
			mem_wdata <= 8'h00;
			hold_addr <= 10'h000;
			prog_req <= 1'b0;
			prog_addr <= 16'h0000;
			skip_next <= 1'b0;
			acc <= `MIX_ACC_RESET;
			tbl_low <= `MIX_TBL_RESET;
			tbl_high <= `MIX_TBL_RESET;
			tbl_latch <= `MIX_TBL_RESET;
			flag_c <= 1'b0;
			flag_z <= 1'b0;
			arith_range_flag <= 1'b0;
			nibble_carry_flag <= 1'b0;
			signed_less_flag <= 1'b0;
		end else begin
			state <= next_state;
			busy <= next_busy;
			mem_we <= next_mem_we;
			mem_waddr <= next_mem_waddr;
			mem_wdata <= next_mem_wdata;
			hold_addr <= next_hold_addr;
			prog_req <= next_prog_req;
			prog_addr <= next_prog_addr;
			skip_next <= next_skip_next;
			acc <= next_acc;
			tbl_low <= next_tbl_low;
			tbl_high <= next_tbl_high;
			tbl_latch <= next_tbl_latch;
			flag_c <= next_c;
			flag_z <= next_z;
			arith_range_flag <= next_range;
			nibble_carry_flag <= next_nib;
			signed_less_flag <= next_sless;
		end
	end

	// ==========================================================
	// checks
	sequence s_issue_skz;
		op_valid && state == MIX_RUN && op == MIX_SKZ && mem_rdata == 8'h00;
	endsequence
	sequence s_skip_slot;
		skip_next && busy ##1 !skip_next;
	endsequence
	a_skip_two_cycle: assert property (@(posedge clk) disable iff (!resetn)
		s_issue_skz |=> s_skip_slot) else $error("skip slot wrong");
	a_swap_nibbles: assert property (@(posedge clk) disable iff (!resetn)
		op_valid && state == MIX_RUN && op == MIX_NIBX
		|=> acc == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} && !mem_we
		&& $stable(flag_z)) else $error("swap wrong");
	a_bit_skip: assert property (@(posedge clk) disable iff (!resetn)
		op_valid && state == MIX_RUN && op == MIX_SKZBIT
		|=> skip_next == !$past(mem_rdata[bit_sel])) else $error("bit skip wrong");
	a_table_addr: assert property (@(posedge clk) disable iff (!resetn)
		op_valid && state == MIX_RUN && op == MIX_ITRDL
		|=> prog_req && prog_addr == {`MIX_LAST_PAGE, $past(tbl_low) + 8'h01})
		else $error("table address wrong");
	a_table_write: assert property (@(posedge clk) disable iff (!resetn)
		state == MIX_TREAD && prog_rvalid
		|=> mem_we && mem_wdata == $past(prog_rdata[7:0])
		&& tbl_latch == $past(prog_rdata[15:8])) else $error("table data wrong");
	a_xor_zero: assert property (@(posedge clk) disable iff (!resetn)
		op_valid && state == MIX_RUN && op == MIX_XOR
		|=> acc == ($past(acc) ^ $past(mem_rdata)) && flag_z == (acc == 8'h00)
		&& $stable(flag_c)) else $error("xor wrong");
	a_add_carry: assert property (@(posedge clk) disable iff (!resetn)
		op_valid && state == MIX_RUN && op == MIX_ADC
		|=> {flag_c, acc} == {1'b0, $past(acc)} + {1'b0, $past(mem_rdata)} + $past(flag_c))
		else $error("adc wrong");
	a_long_section: assert property (@(posedge clk) disable iff (!resetn)
		op_valid && state == MIX_RUN && long_form
		|=> mem_waddr[9:8] == $past(mem_section)) else $error("section wrong");
	a_rlc_carry: assert property (@(posedge clk) disable iff (!resetn)
		op_valid && state == MIX_RUN && op == MIX_RL && rot_mode == MIX_RLCM
		|=> flag_c == $past(mem_rdata[7]) && mem_wdata[0] == $past(flag_c))
		else $error("rlc wrong");
endmodule : mix_exec

// File: mcu_instruction_exec_subset_tb.sv
// self-checking bench for the instruction execution subset
`timescale 1ns/1ps
module mcu_instruction_exec_subset_tb import mix_pkg::*; ;
// ====================
// design ports
logic clk = 1'b0, resetn = 1'b0, op_valid = 1'b0, long_form = 1'b0, prog_rvalid = 1'b0;
mix_op_e op = MIX_NOP;
mix_rot_e rot_mode = MIX_RLM;
logic [2:0] bit_sel = 3'h0;
logic [7:0] imm = 8'h00, mem_addr = 8'h00, mem_rdata = 8'h00;
logic [1:0] mem_section = 2'h0, cur_section = 2'h0;
logic [15:0] prog_rdata = 16'h0000, prog_addr;
logic busy, mem_we, prog_req, skip_next, flag_c, flag_z;
logic arith_range_flag, nibble_carry_flag, signed_less_flag;
logic [9:0] mem_waddr;
logic [7:0] mem_wdata, acc, tbl_low, tbl_high, tbl_latch;
// ====================
// model state
logic [7:0] e_acc = 8'h00, e_tl = 8'h00, e_lat = 8'h00;
logic e_c = 1'b0, e_z = 1'b0, e_rng = 1'b0, e_nib = 1'b0, e_sl = 1'b0;
int n_fail = 0, compares = 0, cyc = 0;
always #2 clk = ~clk;
mix_exec mix_exec_inst (.clk(clk), .resetn(resetn), .op_valid(op_valid), .op(op),
	.rot_mode(rot_mode), .bit_sel(bit_sel), .imm(imm), .mem_addr(mem_addr),
	.mem_section(mem_section), .long_form(long_form), .cur_section(cur_section),
	.mem_rdata(mem_rdata), .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid),
	.busy(busy), .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
	.prog_req(prog_req), .prog_addr(prog_addr), .skip_next(skip_next), .acc(acc),
	.tbl_low(tbl_low), .tbl_high(tbl_high), .tbl_latch(tbl_latch), .flag_c(flag_c),
	.flag_z(flag_z), .arith_range_flag(arith_range_flag),
	.nibble_carry_flag(nibble_carry_flag), .signed_less_flag(signed_less_flag));
// ====================
// checks and closing
task chk(input logic [15:0] g, input logic [15:0] e);
	compares++;
	if (g !== e) begin
		n_fail++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
	end
endtask : chk
task end_of_test;
	$display("compares=%0d n_fail=%0d", compares, n_fail);
	if (n_fail == 0 && compares > 0) begin
		$display("*** PASS ***");
	end else begin
		$display("*** FAIL ***");
	end
	$finish;
endtask : end_of_test
always @(posedge clk) begin
	cyc++;
	if (cyc == 20000) begin
		n_fail++;
		end_of_test();
	end
end
// ====================
// one instruction against the model; rf holds op_valid into the busy time
task automatic exec(input mix_op_e o, input mix_rot_e r, input logic [7:0] md, input logic rf);
	logic [8:0] s;
	logic [7:0] res, im, ma;
	logic [2:0] bs;
	logic [1:0] ms, cs, dst;
	logic lf, ew, es, zf, tr;
	logic [15:0] pa, pw;
	int d;
	bs = 3'($urandom);
	im = 8'($urandom);
	ma = 8'($urandom);
	ms = 2'($urandom);
	cs = 2'($urandom);
	lf = 1'($urandom);
	pw = 16'($urandom);
	dst = 2'h0;
	zf = 1'b0;
	es = 1'b0;
	tr = 1'b0;
	res = 8'h00;
	pa = 16'h0000;
	case (o)
		MIX_NIBX: begin res = {md[3:0], md[7:4]}; dst = 2'h1; end
		MIX_SKZ: es = md == 8'h00;
		MIX_SKZA: begin res = md; dst = 2'h1; es = md == 8'h00; end
		MIX_SKZBIT: es = !md[bs];
		MIX_TRD, MIX_ITRD: begin e_tl += (o == MIX_ITRD); pa = {8'h00, e_tl}; tr = 1'b1; end
		MIX_TRDL, MIX_ITRDL: begin e_tl += (o == MIX_ITRDL); pa = {8'hff, e_tl}; tr = 1'b1; end
		MIX_XOR, MIX_XORMEM, MIX_XORI: begin
			res = e_acc ^ (o == MIX_XORI ? im : md);
			dst = o == MIX_XORMEM ? 2'h2 : 2'h1;
			zf = 1'b1;
		end
		MIX_ADC, MIX_ADCM, MIX_ADD, MIX_ADDM: begin
			d = (o == MIX_ADC || o == MIX_ADCM) ? e_c : 0;
			s = e_acc + md + d;
			e_nib = (e_acc[3:0] + md[3:0] + d) > 15;
			e_rng = e_acc[7] == md[7] && s[7] != e_acc[7];
			e_sl = e_rng ^ s[7];
			e_c = s[8];
			res = s[7:0];
			zf = 1'b1;
			dst = (o == MIX_ADCM || o == MIX_ADDM) ? 2'h2 : 2'h1;
		end
		MIX_AND, MIX_ANDM: begin res = e_acc & md; dst = o == MIX_ANDM ? 2'h2 : 2'h1; zf = 1'b1; end
		MIX_OR, MIX_ORM: begin res = e_acc | md; dst = o == MIX_ORM ? 2'h2 : 2'h1; zf = 1'b1; end
		MIX_CLR: dst = 2'h2;
		MIX_CLRBIT: begin res = md & ~(8'h01 << bs); dst = 2'h2; end
		MIX_CPL, MIX_CPLA: begin res = ~md; dst = o == MIX_CPL ? 2'h2 : 2'h1; zf = 1'b1; end
		MIX_DAA: begin
			s = e_acc;
			if (e_acc[3:0] > 9 || e_nib) s += 9'h006;
			if (s[7:4] > 9 || e_c || s[8]) begin
				s += 9'h060;
				e_c = 1'b1;
			end
			res = s[7:0];
			dst = 2'h2;
		end
		MIX_DEC, MIX_DECA: begin res = md - 8'h01; dst = o == MIX_DEC ? 2'h2 : 2'h1; zf = 1'b1; end
		MIX_INC, MIX_INCA: begin res = md + 8'h01; dst = o == MIX_INC ? 2'h2 : 2'h1; zf = 1'b1; end
		MIX_MOVA: begin res = md; dst = 2'h1; end
		MIX_MOVM: begin res = e_acc; dst = 2'h2; end
		MIX_RL: begin
			res = {md[6:0], r == MIX_RLCM ? e_c : md[7]};
			if (r == MIX_RLCM) e_c = md[7];
			dst = r == MIX_RLA ? 2'h1 : 2'h2;
		end
		default: ;
	endcase
	if (dst == 2'h1) e_acc = res;
	if (zf) e_z = res == 8'h00;
	ew = dst == 2'h2 || tr;
	if (tr) begin res = pw[7:0]; e_lat = pw[15:8]; end
	@(posedge clk);
	op_valid <= 1'b1;
	op <= o;
	rot_mode <= r;
	bit_sel <= bs;
	imm <= im;
	mem_addr <= ma;
	mem_section <= ms;
	long_form <= lf;
	cur_section <= cs;
	mem_rdata <= md;
	@(posedge clk);
	if (rf) begin op <= MIX_MOVA; mem_rdata <= ~md; end else op_valid <= 1'b0;
	#1;
	if (tr) begin
		chk(busy, 1);
		chk(prog_req, 1);
		chk(prog_addr, pa);
		d = $urandom % 4;
		repeat (d + 1) @(posedge clk);
		prog_rvalid <= 1'b1;
		prog_rdata <= pw;
		op_valid <= 1'b0;
		@(posedge clk);
		prog_rvalid <= 1'b0;
		prog_rdata <= ~pw;
		#1;
		chk(busy, 0);
		chk(prog_req, 0);
	end
	chk(mem_we, ew);
	if (ew) begin chk(mem_waddr, {lf ? ms : cs, ma}); chk(mem_wdata, res); end
	chk(skip_next, es);
	chk(acc, e_acc);
	chk(tbl_low, e_tl);
	chk(tbl_high, 16'h0000);
	chk(tbl_latch, e_lat);
	chk(flag_c, e_c);
	chk(flag_z, e_z);
	chk(arith_range_flag, e_rng);
	chk(nibble_carry_flag, e_nib);
	chk(signed_less_flag, e_sl);
	if (es) begin
		chk(busy, 1);
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
		chk(skip_next, 0);
		chk(busy, 0);
		chk(acc, e_acc);
	end
endtask : exec
// ====================
// main sequence
initial begin
	mix_op_e o;
	void'($urandom(32'h1d6432ff));
	repeat (16) @(posedge clk);
	resetn <= 1'b1;
	#1;
	chk({acc, tbl_latch}, 16'h0000);
	chk({busy, mem_we, skip_next, prog_req, flag_c, flag_z}, 16'h0000);
	exec(MIX_MOVA, MIX_RLM, 8'h9a, 1'b0);
	exec(MIX_DAA, MIX_RLM, 8'h55, 1'b0);
	exec(MIX_MOVA, MIX_RLM, 8'h3c, 1'b0);
	exec(MIX_DAA, MIX_RLM, 8'h00, 1'b0);
	exec(MIX_SKZ, MIX_RLM, 8'h00, 1'b1);
	exec(MIX_SKZ, MIX_RLM, 8'h01, 1'b0);
	exec(MIX_SKZA, MIX_RLM, 8'h00, 1'b1);
	exec(MIX_SKZBIT, MIX_RLM, 8'h00, 1'b1);
	exec(MIX_SKZBIT, MIX_RLM, 8'hff, 1'b0);
	exec(MIX_TRD, MIX_RLM, 8'h00, 1'b1);
	exec(MIX_TRDL, MIX_RLM, 8'h00, 1'b1);
	exec(MIX_ITRD, MIX_RLM, 8'h00, 1'b1);
	exec(MIX_ITRDL, MIX_RLM, 8'h00, 1'b1);
	exec(MIX_RL, MIX_RLCM, 8'h80, 1'b0);
	// decimal adjust stays directed: its carry reading is only pinned for these cases
	for (int i = 0; i < 400; i++) begin
		o = mix_op_e'(5'($urandom));
		if (o == MIX_NOP || o == MIX_DAA) o = MIX_MOVM;
		exec(o, mix_rot_e'($urandom % 3), ($urandom % 4 == 0) ? 8'h00 : 8'($urandom), 1'b0);
	end
	end_of_test();
end
endmodule : mcu_instruction_exec_subset_tb
